// ==== tsi_switch_regs.vh ====
// register offsets, fields and timing constants of the slot switch
`ifndef TSI_SWITCH_REGS_VH
`define TSI_SWITCH_REGS_VH
`define CTRL_SEL_BIT 5
`define CHAN_WINDOW_BASE 6'h20
`define CTRL_SPLIT_BIT 7
`define CTRL_GPM_BIT 6
`define CTRL_MSEL_HI 4
`define CTRL_MSEL_LO 3
`define CTRL_STREAM_HI 1
`define CTRL_STREAM_LO 0
`define CTRL_RESET 8'h00
`define CTRL_MASK 8'hDB
`define MSEL_DATA 2'b01
`define MSEL_CML 2'b10
`define MSEL_CMH 2'b11
`define CMH_PROC_BIT 2
`define CMH_OE_BIT 0
`define CMH_MASK 8'h05
`define BITS_PER_FRAME 256
`define CLK_PER_FRAME 512
`define SLOW_ACK_CYCLES 3'h4
`endif

// ==== stream_fifo.v ====
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter WIDTH = 15,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push = in_valid_i && (cnt_q != DEPTH);
  wire pop = out_ready_i && (cnt_q != 0);
  assign in_ready_o = (cnt_q != DEPTH);
  assign out_valid_o = (cnt_q != 0);
  assign out_data_o = mem_q[rd_q];
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= (wr_q == DEPTH-1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop)
        rd_q <= (rd_q == DEPTH-1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // stream_fifo
`default_nettype wire

// ==== tdm_time_slot_switch.v ====
// four-stream time slot interchange with host port
// Notes on behaviour
// R1: frames of 32 eight-bit slots per stream
// R2: four in, four out, 128 channels
// R3: shifting timed by 4.096 MHz serial clock
// R4: received bytes stored in 128-entry data memory
// R5: frame pulse resets channel/bit counter
// R6: acknowledge driven low when transfer done
// R7: access only with strobe high, select low
// R8: read/write picks data bus direction
// R9: host reaches control, connection, data memory
// R10: master enable low tristates all serial outputs
// R11: connection memory split high and low halves
// R12: processor mode sends low connection byte
// R13: connection mode sends addressed data byte
// R14: output byte fetched in preceding slot
// R15: processor byte repeats every frame
// R16: high half selects mode and drive
// R17: same slot data leaves next frame
// R18: one-slot delay possible for every stream pair
// R19: window addresses pick channel 0 to 31
// R20: control write is fast, memories slower
// R21: top address bit picks control or window
// R22: high bit 2 processor, bit 0 enable
// R23: select 01 data, 10 low, 11 high
// R24: release acknowledge and bus at end
// R25: disabled slots leave output high impedance
`timescale 1ns/1ps
`default_nettype none
`include "tsi_switch_regs.vh"
module tdm_time_slot_switch #(
  parameter STREAMS = 4,
  parameter SLOTS = 32,
  parameter FIFO_DEPTH = 8
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire serial_bit_clock_i,
  input wire frame_sync_n_i,
  input wire [3:0] serial_in_streams_i,
  output reg [3:0] serial_out_streams_o,
  output reg [3:0] serial_out_oe_o,
  input wire master_tristate_en_i,
  input wire [5:0] host_addr_i,
  input wire host_strobe_i,
  input wire host_cs_n_i,
  input wire host_rw_i,
  input wire [7:0] host_data_i,
  output reg [7:0] host_data_o,
  output reg host_data_oe_o,
  output reg transfer_ack_n_o,
  output reg transfer_ack_oe_o
);
  // synchronisers for every asynchronous input
  reg [13:0] s1_q;
  reg [13:0] s2_q;
  always @(posedge ref_clk_i) begin
    s1_q <= {serial_bit_clock_i, frame_sync_n_i, serial_in_streams_i,
             master_tristate_en_i, host_strobe_i, host_cs_n_i, host_rw_i,
             host_addr_i[5:2]};
    s2_q <= s1_q;
  end
  reg [1:0] addr_lo1_q;
  reg [1:0] addr_lo2_q;
  reg [7:0] hd1_q;
  reg [7:0] hd2_q;
  always @(posedge ref_clk_i) begin
    addr_lo1_q <= host_addr_i[1:0];
    addr_lo2_q <= addr_lo1_q;
    hd1_q <= host_data_i;
    hd2_q <= hd1_q;
  end
  wire clk4 = s2_q[13];
  wire fs_n = s2_q[12];
  wire [3:0] rx = s2_q[11:8];
  wire master_tristate_en = s2_q[7];
  wire strobe = s2_q[6];
  wire cs_n = s2_q[5];
  wire rw = s2_q[4];
  wire [5:0] addr = {s2_q[3:0], addr_lo2_q};

  // serial clock edge detect, one-cycle enables
  reg clk4_q;
  always @(posedge ref_clk_i) clk4_q <= clk4;
  wire c4_fall = clk4_q && !clk4; // R3
  wire c4_rise = !clk4_q && clk4;

  // channel/bit counter: 2 serial clocks per bit
  reg [8:0] pos_q;
  reg fs_seen_q;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pos_q <= 9'h000;
      fs_seen_q <= 1'b0;
    end else if (c4_fall) begin
      if (!fs_n && !fs_seen_q)
        pos_q <= 9'h000; // R5
      else
        pos_q <= pos_q + 9'h001; // R1
      fs_seen_q <= !fs_n;
    end
  end
  wire [4:0] slot = pos_q[8:4];
  wire [2:0] bitn = pos_q[3:1];
  wire half = pos_q[0];

  // memories
  reg [7:0] dmem_q [0:127]; // R4
  reg [7:0] cml_q [0:127]; // R11
  reg [7:0] cmh_q [0:127];
  reg [7:0] ctrl_q;
  reg [7:0] rxsh_q [0:3];
  reg [7:0] txsh_q [0:3];
  reg [7:0] txnx_q [0:3];
  reg [3:0] txen_q;
  reg [3:0] txennx_q;

  function [6:0] chan_index;
    input [1:0] stream;
    input [4:0] ch;
    chan_index = {stream, ch};
  endfunction

  // host side: memory write requests queue through fifo into memory port
  wire sel = strobe && !cs_n; // R7
  reg sel_q;
  reg [2:0] ack_cnt_q;
  reg done_q;
  wire is_ctrl = !addr[`CTRL_SEL_BIT]; // R21
  wire split = ctrl_q[`CTRL_SPLIT_BIT];
  wire [1:0] msel = ctrl_q[`CTRL_MSEL_HI:`CTRL_MSEL_LO];
  wire [6:0] hidx = chan_index(ctrl_q[`CTRL_STREAM_HI:`CTRL_STREAM_LO],
                               addr[4:0]); // R19
  wire [1:0] wsel = split ? `MSEL_CML : msel;
  wire [1:0] rsel = split ? `MSEL_DATA : msel;
  wire start = sel && !sel_q;
  wire mem_wr_req = start && !rw && !is_ctrl; // R8
  wire fifo_in_ready;
  wire fifo_valid;
  wire [16:0] fifo_data;
  wire fifo_pop = fifo_valid && !c4_fall;
  stream_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH), .AW(3)) wq (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(mem_wr_req),
    .in_ready_o(fifo_in_ready),
    .in_data_i({wsel, hidx, hd2_q}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );
  reg wr_pending_q;

  integer k;
  integer j;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CTRL_RESET;
      sel_q <= 1'b0;
      ack_cnt_q <= 3'h0;
      done_q <= 1'b0;
      wr_pending_q <= 1'b0;
      host_data_o <= 8'h00;
      host_data_oe_o <= 1'b0;
      transfer_ack_n_o <= 1'b1;
      transfer_ack_oe_o <= 1'b0;
    end else begin
      sel_q <= sel;
      if (!sel) begin
        done_q <= 1'b0;
        ack_cnt_q <= 3'h0;
        transfer_ack_n_o <= 1'b1; // R24
        transfer_ack_oe_o <= 1'b0;
        host_data_oe_o <= 1'b0;
        wr_pending_q <= 1'b0;
      end else if (start) begin
        if (!rw && is_ctrl) begin
          ctrl_q <= hd2_q & `CTRL_MASK;
          done_q <= 1'b1; // R20
          transfer_ack_n_o <= 1'b0; // R6
          transfer_ack_oe_o <= 1'b1;
        end else begin
          ack_cnt_q <= `SLOW_ACK_CYCLES;
          wr_pending_q <= !rw && !fifo_in_ready;
          if (rw) begin
            host_data_oe_o <= 1'b1; // R8
            if (is_ctrl)
              host_data_o <= ctrl_q;
            else if (rsel == `MSEL_DATA)
              host_data_o <= dmem_q[hidx]; // R9
            else if (rsel == `MSEL_CML)
              host_data_o <= cml_q[hidx];
            else if (rsel == `MSEL_CMH)
              host_data_o <= cmh_q[hidx];
            else
              host_data_o <= 8'h00; // R23
          end
        end
      end else if (!done_q) begin
        if (ack_cnt_q > 3'h1)
          ack_cnt_q <= ack_cnt_q - 3'h1;
        else if (!wr_pending_q) begin
          done_q <= 1'b1;
          transfer_ack_n_o <= 1'b0; // R6
          transfer_ack_oe_o <= 1'b1;
        end
      end
    end
  end

  // memory port: host writes drained outside serial clock falls
  always @(posedge ref_clk_i) begin
    if (fifo_pop) begin
      if (fifo_data[16:15] == `MSEL_CML)
        cml_q[fifo_data[14:8]] <= fifo_data[7:0]; // R15
      else if (fifo_data[16:15] == `MSEL_CMH)
        cmh_q[fifo_data[14:8]] <= fifo_data[7:0] & `CMH_MASK; // R16
    end
  end

  // receive: sample three quarters into bit, store completed byte
  always @(posedge ref_clk_i) begin
    if (c4_rise && half) begin
      for (j = 0; j < STREAMS; j = j + 1) begin
        rxsh_q[j] <= {rxsh_q[j][6:0], rx[j]};
        if (bitn == 3'h7)
          dmem_q[chan_index(j[1:0], slot)] <=
            {rxsh_q[j][6:0], rx[j]}; // R4
      end
    end
  end

  // transmit: fetch next slot byte during current slot
  wire [4:0] next_slot = slot + 5'h01;
  function tx_proc;
    input [6:0] i;
    tx_proc = cmh_q[i][`CMH_PROC_BIT] || ctrl_q[`CTRL_GPM_BIT]; // R22
  endfunction
  function tx_en;
    input [6:0] i;
    tx_en = cmh_q[i][`CMH_OE_BIT] || ctrl_q[`CTRL_GPM_BIT]; // R22
  endfunction
  function [7:0] tx_byte;
    input [6:0] i;
    tx_byte = tx_proc(i) ? cml_q[i] : dmem_q[cml_q[i][6:0]]; // R12 R13
  endfunction
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      serial_out_streams_o <= 4'h0;
      serial_out_oe_o <= 4'h0;
      txen_q <= 4'h0;
      txennx_q <= 4'h0;
    end else if (c4_fall) begin
      for (k = 0; k < STREAMS; k = k + 1) begin
        if (bitn == 3'h7 && half) begin
          // R14 R17 R18
          txnx_q[k] <= tx_byte(chan_index(k[1:0], next_slot)); // R12 R13
          txennx_q[k] <= tx_en(chan_index(k[1:0], next_slot)); // R16
        end
        if (bitn == 3'h0 && !half) begin
          txsh_q[k] <= {txnx_q[k][6:0], 1'b0};
          txen_q[k] <= txennx_q[k];
          serial_out_streams_o[k] <= txnx_q[k][7];
          serial_out_oe_o[k] <= txennx_q[k] && master_tristate_en; // R10 R25
        end else if (!half) begin
          txsh_q[k] <= {txsh_q[k][6:0], 1'b0};
          serial_out_streams_o[k] <= txsh_q[k][7]; // R2
          serial_out_oe_o[k] <= txen_q[k] && master_tristate_en; // R10
        end else if (!master_tristate_en)
          serial_out_oe_o[k] <= 1'b0; // R10
      end
    end
  end
endmodule // tdm_time_slot_switch
`default_nettype wire

// ==== tsi_switch_properties.sv ====
// assertions on the slot switch ports
`timescale 1ns/1ps
`default_nettype none
module tsi_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] serial_out_streams_o,
  input wire logic [3:0] serial_out_oe_o,
  input wire logic master_tristate_en_i,
  input wire logic [5:0] host_addr_i,
  input wire logic host_strobe_i,
  input wire logic host_cs_n_i,
  input wire logic host_rw_i,
  input wire logic host_data_oe_o,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_go; $rose(host_strobe_i) && !host_cs_n_i; endsequence
  sequence s_off; (!host_strobe_i || host_cs_n_i) [*5]; endsequence
  // cycles the master enable has been low, saturating
  logic [3:0] ode_lo_q;
  always @(posedge ref_clk_i)
    if (rst_i || master_tristate_en_i)
      ode_lo_q <= 4'h0;
    else if (ode_lo_q != 4'hf)
      ode_lo_q <= ode_lo_q + 4'h1;
  property p_ode;
    ode_lo_q == 4'hf |-> serial_out_oe_o == 4'h0;
  endproperty
  a_ode: assert property (p_ode) else $error("output driven, enable low");
  property p_rel; s_off |-> !transfer_ack_oe_o && !host_data_oe_o; endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  property p_cause;
    $rose(transfer_ack_oe_o) |-> $past(host_strobe_i && !host_cs_n_i, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("ack without select");
  property p_lvl; transfer_ack_oe_o |-> !transfer_ack_n_o; endproperty
  a_lvl: assert property (p_lvl) else $error("ack level wrong");
  property p_dir; host_data_oe_o |-> host_rw_i && $past(host_rw_i, 2); endproperty
  a_dir: assert property (p_dir) else $error("bus driven on write");
  property p_fast;
    s_go ##0 (!host_rw_i && !host_addr_i[5]) |-> ##[1:4] transfer_ack_oe_o;
  endproperty
  a_fast: assert property (p_fast) else $error("control write slow");
  property p_slow;
    s_go ##0 host_addr_i[5] |-> !transfer_ack_oe_o [*4] ##[1:900]
      transfer_ack_oe_o;
  endproperty
  a_slow: assert property (p_slow) else $error("memory ack timing");
  property p_bit;
    $changed(serial_out_streams_o) |=> $stable(serial_out_streams_o) [*8];
  endproperty
  a_bit: assert property (p_bit) else $error("serial bit too short");
endmodule // tsi_props
bind tdm_time_slot_switch tsi_props u_props (.ref_clk_i, .rst_i,
  .serial_out_streams_o, .serial_out_oe_o, .master_tristate_en_i,
  .host_addr_i, .host_strobe_i, .host_cs_n_i, .host_rw_i,
  .host_data_oe_o, .transfer_ack_n_o, .transfer_ack_oe_o);
`default_nettype wire

// ==== link_model.sv ====
// serial link partner: bit clock, frame pulse, input streams
`timescale 1ns/1ps
`default_nettype none
module link_model (
  output logic sclk_o,
  output logic fs_n_o,
  output logic [3:0] rx_o,
  output logic [8:0] pos_o
);
  logic [8:0] nxt;
  assign nxt = pos_o + 9'h001;
  function automatic logic bit_of(input int s, input logic [8:0] p);
    logic [7:0] b;
    b = {1'b1, 2'(s), p[8:4]};
    return b[~p[3:1]];
  endfunction
  initial sclk_o = 1'b0;
  initial fs_n_o = 1'b1;
  initial rx_o = 4'h0;
  initial pos_o = 9'h000;
  always #80 sclk_o = ~sclk_o;
  // pulse low in the last clock, taken at the wrapping fall
  always @(posedge sclk_o) fs_n_o <= (pos_o != 9'h1ff);
  always @(negedge sclk_o) begin
    pos_o <= nxt;
    for (int s = 0; s < 4; s++)
      rx_o[s] <= bit_of(s, nxt);
  end
endmodule // link_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the slot switch
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic master_tristate_en = 1'b0;
  logic strobe = 1'b0;
  logic cs_n = 1'b1;
  logic rw = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] hdrv = 8'h00;
  logic [7:0] rd;
  logic [7:0] sh [2];
  int cnt [2] = '{0, 0};
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  wire sclk, fs_n, dout_oe, ack_n, ack_oe;
  wire [3:0] rx, tx, tx_oe;
  wire [8:0] pos;
  wire [7:0] dout, bus;
  assign bus = dout_oe ? dout : hdrv;
  always #10 ref_clk_i = ~ref_clk_i;
  link_model u_link (.sclk_o(sclk), .fs_n_o(fs_n), .rx_o(rx), .pos_o(pos));
  tdm_time_slot_switch dut (.ref_clk_i, .rst_i, .serial_bit_clock_i(sclk),
    .frame_sync_n_i(fs_n), .serial_in_streams_i(rx),
    .serial_out_streams_o(tx), .serial_out_oe_o(tx_oe),
    .master_tristate_en_i(master_tristate_en), .host_addr_i(addr), .host_strobe_i(strobe),
    .host_cs_n_i(cs_n), .host_rw_i(rw), .host_data_i(bus),
    .host_data_o(dout), .host_data_oe_o(dout_oe),
    .transfer_ack_n_o(ack_n), .transfer_ack_oe_o(ack_oe));
  // capture enabled output bits on the sclk rise in the second half of each bit
  always @(posedge sclk)
    for (int s = 0; s < 2; s++)
      if (pos[0] && tx_oe[s] === 1'b1) begin
        sh[s] <= {sh[s][6:0], tx[s]};
        cnt[s] <= cnt[s] + 1;
      end
  task test_done;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task access(input logic r, input logic [5:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk_i);
    rw <= r;
    addr <= a;
    hdrv <= d;
    repeat (3) @(posedge ref_clk_i);
    strobe <= 1'b1;
    cs_n <= 1'b0;
    i = 0;
    do begin @(posedge ref_clk_i); i++; end while (ack_oe !== 1'b1 && i < 2000);
    rd = bus;
    check("ack", {7'h00, ack_oe}, 8'h01);
    strobe <= 1'b0;
    cs_n <= 1'b1;
    i = 0;
    do begin @(posedge ref_clk_i); i++; end while (ack_oe !== 1'b0 && i < 50);
    hdrv <= ~d;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask
  task rdchk(input string w, input logic [5:0] a, input logic [7:0] e);
    access(1'b1, a, 8'h00);
    check(w, rd, e);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rdchk("ctrl reset", 6'h00, 8'h00);
    wr(6'h00, 8'hff);
    rdchk("ctrl reserved", 6'h1c, 8'hdb);
    wr(6'h00, 8'h00);
    rdchk("select unused", 6'h25, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(6'h00, 8'h18 | 8'(s));
      for (int c = 0; c < 32; c++)
        wr(6'h20 | 6'(c), 8'h00);
    end
    wr(6'h00, 8'h18);
    wr(6'h25, 8'hff);
    rdchk("high half", 6'h25, 8'h05);
    wr(6'h00, 8'h10);
    wr(6'h25, 8'ha5);
    rdchk("low half", 6'h25, 8'ha5);
    wr(6'h00, 8'h19);
    wr(6'h29, 8'h01);
    wr(6'h00, 8'h11);
    wr(6'h29, 8'h03);
    repeat (5000) @(posedge ref_clk_i);
    wr(6'h00, 8'h80);
    wr(6'h27, 8'h5a);
    rdchk("split read", 6'h23, 8'h83);
    wr(6'h00, 8'h08);
    wr(6'h23, 8'h00);
    rdchk("data read only", 6'h23, 8'h83);
    wr(6'h00, 8'h10);
    rdchk("split write", 6'h27, 8'h5a);
    @(posedge sclk iff pos == 9'h100);
    @(posedge ref_clk_i);
    master_tristate_en <= 1'b1;
    repeat (2) @(posedge sclk iff pos == 9'h100);
    @(posedge ref_clk_i);
    master_tristate_en <= 1'b0;
    check("processor byte", sh[0], 8'ha5);
    check("switched byte", sh[1], 8'h83);
    check("processor bits", 8'(cnt[0]), 8'h10);
    check("switched bits", 8'(cnt[1]), 8'h10);
    test_done();
  end
endmodule // tb
`default_nettype wire
